// File: hdl/crf_pkg.sv
// Constants and types shared by the architectural register file
package crf_pkg;

  // Data widths and register counts
  localparam int CRF_NREG = 16;
  localparam int CRF_DW = 32;
  localparam int CRF_WW = 16;
  localparam int CRF_BW = 8;

  // General register indices with a fixed role
  localparam logic [3:0] CRF_IDX_R0 = 4'h0;
  localparam logic [3:0] CRF_IDX_R1 = 4'h1;
  localparam logic [3:0] CRF_IDX_R2 = 4'h2;
  localparam logic [3:0] CRF_IDX_R11 = 4'hB;
  localparam logic [3:0] CRF_IDX_R12 = 4'hC;
  localparam logic [3:0] CRF_IDX_R13 = 4'hD;
  localparam logic [3:0] CRF_IDX_RET = 4'hE;
  localparam logic [3:0] CRF_IDX_SP = 4'hF;

  // Address space: 24 significant bits, instructions and pointers even
  localparam logic [31:0] CRF_ADDR_MASK = 32'h00FF_FFFF;
  localparam logic [31:0] CRF_PTR_MASK = 32'h00FF_FFFE;
  localparam logic [31:0] CRF_PC_RESET = 32'h0000_0000;

  // Status word bit positions
  localparam int CRF_PSW_C = 0;
  localparam int CRF_PSW_T = 1;
  localparam int CRF_PSW_L = 2;
  localparam int CRF_PSW_U = 3;
  localparam int CRF_PSW_F = 5;
  localparam int CRF_PSW_Z = 6;
  localparam int CRF_PSW_N = 7;
  localparam int CRF_PSW_E = 9;
  localparam int CRF_PSW_P = 10;
  localparam int CRF_PSW_I = 11;

  // Writable status bits, value after reset, bits kept over a core reset
  localparam logic [15:0] CRF_PSW_WMASK = 16'h0EEF;
  localparam logic [15:0] CRF_PSW_RESET = 16'h0200;
  localparam logic [15:0] CRF_PSW_KEEP = 16'hF000;

  // Operand size of a general register access
  typedef enum logic [1:0] {
    CRF_SZ_BYTE,
    CRF_SZ_WORD,
    CRF_SZ_DWORD
  } crf_size_t;

  // Processor register selector; other codes are not implemented
  typedef enum logic [2:0] {
    CRF_PR_STATUS,
    CRF_PR_EXC_SP,
    CRF_PR_USER_SP,
    CRF_PR_DISPATCH,
    CRF_PR_NONE
  } crf_preg_t;

endpackage

// File: hdl/crf_read_port.sv
// Operand read port: pairing, size selection and extension
`timescale 1ns/1ps
module crf_read_port
  import crf_pkg::*;
(
  // Register array
  input wire logic [CRF_NREG-1:0][CRF_DW-1:0] gpr,
  input wire logic short_register_select,
  // Request
  input wire logic [3:0] idx,
  input wire crf_size_t size,
  input wire logic sign_ext,
  // Result
  output logic [CRF_DW-1:0] data
);

  logic [3:0] idx_hi;
  logic [CRF_WW-1:0] lo_w;
  logic [CRF_BW-1:0] lo_b;

  assign idx_hi = idx + 4'h1;
  assign lo_w = gpr[idx][CRF_WW-1:0];
  assign lo_b = gpr[idx][CRF_BW-1:0];

  always_comb
  begin
    data = '0;
    case (size)
      CRF_SZ_BYTE:
        data = {{(CRF_DW-CRF_BW){sign_ext & lo_b[CRF_BW-1]}}, lo_b};
      CRF_SZ_WORD:
        data = {{(CRF_DW-CRF_WW){sign_ext & lo_w[CRF_WW-1]}}, lo_w};
      default:
      begin
        if (idx == CRF_IDX_SP)
          data = gpr[idx];
        else if (!short_register_select && idx >= CRF_IDX_R12)
          data = gpr[idx];
        else if (idx == CRF_IDX_RET)
          data = {{(CRF_DW-CRF_WW){1'b0}}, lo_w};
        else
          data = {gpr[idx_hi][CRF_WW-1:0], lo_w};
      end
    endcase
  end

endmodule

// File: hdl/crf_core_regs.sv
// Architectural register set of the processor core
`timescale 1ns/1ps
// Behaviour
// - Program counter, exception stack pointer and dispatch base keep only 24 significant address bits.
// - Little-endian: byte lane zero of any value is its lowest address.
// - Byte, word and double-word operands, signed or unsigned extension.
// - A boolean operand is judged by its lowest bit alone.
// - Reading an unimplemented processor register returns zero.
// - Sixteen general registers, used alone or paired for 32-bit values.
// - Short mode pairs adjacent low halves; top low pair aliases return address.
// - Long mode: R12, R13, return address and stack pointer are 32 bits.
// - Byte operations touch only the low byte of a register.
// - Word operations on a pair use only the lower register.
// - Program counter is always even.
// - Reset loads the program counter with a fixed start address.
// - Reset copies the old program counter into R1 and R0.
// - Exception stack pointer keeps top eight bits and bit zero at zero.
// - Exception stack pointer moves only on exception entry, return, init.
// - Push or pop with user stack above 24-bit range raises a trap.
// - Dispatch base keeps top eight bits and bit zero at zero.
// - Status word layout I,P,E,N,Z,F,U,L,T,C at their fixed bits.
// - Reset clears status bits 0-11 but sets E, old status into R2.
// - Status bits 4 and 8 always read zero.
module crf_core_regs
  import crf_pkg::*;
(
  // Clock and resets
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic core_reset,
  // Mode
  input wire logic short_register_select,
  // Operand read port A
  input wire logic [3:0] rd_a_idx,
  input wire crf_size_t rd_a_size,
  input wire logic rd_a_signed,
  // Operand read port B
  input wire logic [3:0] rd_b_idx,
  input wire crf_size_t rd_b_size,
  input wire logic rd_b_signed,
  // Operand write port
  input wire logic wr_en,
  input wire logic [3:0] wr_idx,
  input wire crf_size_t wr_size,
  input wire logic [CRF_DW-1:0] wr_data,
  // Program counter load
  input wire logic pc_load,
  input wire logic [CRF_DW-1:0] pc_value,
  // Processor register access
  input wire logic preg_rd,
  input wire logic preg_wr,
  input wire crf_preg_t preg_sel,
  input wire logic [CRF_DW-1:0] preg_wdata,
  // Exception stack movement in bytes
  input wire logic exc_push,
  input wire logic exc_pop,
  input wire logic [4:0] exc_bytes,
  // User stack modifying instruction
  input wire logic stack_op,
  // Operand results, one cycle after the request
  output logic [CRF_DW-1:0] rd_a_data,
  output logic [CRF_DW-1:0] rd_b_data,
  output logic rd_a_bool,
  output logic [CRF_DW-1:0] preg_rdata,
  // Architectural state
  output logic [CRF_DW-1:0] pc,
  output logic [CRF_WW-1:0] processor_status_word,
  output logic [CRF_DW-1:0] exception_stack_pointer,
  output logic [CRF_DW-1:0] dispatch_table_base,
  output logic user_mode,
  output logic illegal_address_trap,
  output logic preg_refused
);

  typedef struct packed {
    logic [CRF_NREG-1:0][CRF_DW-1:0] gpr;
    logic [CRF_DW-1:0] pc;
    logic [CRF_WW-1:0] psw;
    logic [CRF_DW-1:0] esp;
    logic [CRF_DW-1:0] user_stack_pointer;
    logic [CRF_DW-1:0] dtb;
    logic [CRF_DW-1:0] rd_a;
    logic [CRF_DW-1:0] rd_b;
    logic rd_a_bool;
    logic [CRF_DW-1:0] preg_rdata;
    logic trap;
    logic refused;
  } crf_state_t;

  localparam crf_state_t CRF_STATE_RESET = '{
    gpr: '0,
    pc: CRF_PC_RESET,
    psw: CRF_PSW_RESET,
    esp: '0,
    user_stack_pointer: '0,
    dtb: '0,
    rd_a: '0,
    rd_b: '0,
    rd_a_bool: 1'b0,
    preg_rdata: '0,
    trap: 1'b0,
    refused: 1'b0
  };

  crf_state_t st_q;
  crf_state_t st_d;
  logic [CRF_DW-1:0] port_a;
  logic [CRF_DW-1:0] port_b;
  logic [3:0] wr_hi;
  logic wide_reg;
  logic [CRF_DW-1:0] esp_step;

  crf_read_port u_port_a (
    .gpr(st_q.gpr),
    .short_register_select(short_register_select),
    .idx(rd_a_idx),
    .size(rd_a_size),
    .sign_ext(rd_a_signed),
    .data(port_a)
  );

  crf_read_port u_port_b (
    .gpr(st_q.gpr),
    .short_register_select(short_register_select),
    .idx(rd_b_idx),
    .size(rd_b_size),
    .sign_ext(rd_b_signed),
    .data(port_b)
  );

  assign wr_hi = wr_idx + 4'h1;
  // Registers that hold a whole double word by themselves
  assign wide_reg = (wr_idx == CRF_IDX_SP) ||
    (!short_register_select && wr_idx >= CRF_IDX_R12);
  assign esp_step = {{(CRF_DW-5){1'b0}}, exc_bytes};

  always_comb
  begin
    st_d = st_q;

    // Operand reads, lane zero is the lowest memory byte
    st_d.rd_a = port_a;
    st_d.rd_b = port_b;
    st_d.rd_a_bool = port_a[0];

    // Operand write
    if (wr_en)
    begin
      case (wr_size)
        CRF_SZ_BYTE:
          st_d.gpr[wr_idx][CRF_BW-1:0] = wr_data[CRF_BW-1:0];
        CRF_SZ_WORD:
          st_d.gpr[wr_idx][CRF_WW-1:0] = wr_data[CRF_WW-1:0];
        default:
        begin
          if (wide_reg)
            st_d.gpr[wr_idx] = wr_data;
          else if (wr_idx == CRF_IDX_RET)
            st_d.gpr[wr_idx][CRF_WW-1:0] = wr_data[CRF_WW-1:0];
          else
          begin
            st_d.gpr[wr_idx][CRF_WW-1:0] = wr_data[CRF_WW-1:0];
            st_d.gpr[wr_hi][CRF_WW-1:0] = wr_data[CRF_DW-1:CRF_WW];
          end
        end
      endcase
    end

    // Program counter follows the pipeline
    if (pc_load)
      st_d.pc = pc_value & CRF_PTR_MASK;

    // Exception entry moves the stack down, return moves it up
    if (exc_push)
      st_d.esp = (st_q.esp - esp_step) & CRF_PTR_MASK;
    else if (exc_pop)
      st_d.esp = (st_q.esp + esp_step) & CRF_PTR_MASK;

    // Processor register reads
    st_d.refused = 1'b0;
    if (preg_rd)
    begin
      if (preg_sel == CRF_PR_STATUS)
        st_d.preg_rdata = {{(CRF_DW-CRF_WW){1'b0}}, st_q.psw};
      else if (preg_sel == CRF_PR_EXC_SP)
        st_d.preg_rdata = st_q.esp;
      else if (preg_sel == CRF_PR_USER_SP)
        st_d.preg_rdata = st_q.user_stack_pointer;
      else if (preg_sel == CRF_PR_DISPATCH)
        st_d.preg_rdata = st_q.dtb;
      else
        st_d.preg_rdata = '0;
    end

    // Processor register writes are not allowed in user mode
    if (preg_wr && st_q.psw[CRF_PSW_U])
      st_d.refused = 1'b1;
    else if (preg_wr)
    begin
      if (preg_sel == CRF_PR_STATUS)
        st_d.psw = preg_wdata[CRF_WW-1:0] & CRF_PSW_WMASK;
      else if (preg_sel == CRF_PR_EXC_SP)
        st_d.esp = preg_wdata & CRF_PTR_MASK;
      else if (preg_sel == CRF_PR_USER_SP)
        st_d.user_stack_pointer = preg_wdata;
      else if (preg_sel == CRF_PR_DISPATCH)
        st_d.dtb = preg_wdata & CRF_PTR_MASK;
    end

    // User stack beyond the address space traps on push or pop
    st_d.trap = stack_op && ((st_q.user_stack_pointer & ~CRF_ADDR_MASK) != '0);

    // Core reset keeps the previous values in R1:R0 and R2
    if (core_reset)
    begin
      st_d.pc = CRF_PC_RESET;
      st_d.gpr[CRF_IDX_R0] = {{(CRF_DW-CRF_WW){1'b0}}, st_q.pc[CRF_WW-1:0]};
      st_d.gpr[CRF_IDX_R1] = {{(CRF_DW-CRF_WW){1'b0}}, st_q.pc[CRF_DW-1:CRF_WW]};
      st_d.gpr[CRF_IDX_R2] = {{(CRF_DW-CRF_WW){1'b0}}, st_q.psw};
      st_d.psw = (st_q.psw & CRF_PSW_KEEP) | CRF_PSW_RESET;
      st_d.trap = 1'b0;
      st_d.refused = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      st_q <= CRF_STATE_RESET;
    else
      st_q <= st_d;
  end

  assign rd_a_data = st_q.rd_a;
  assign rd_b_data = st_q.rd_b;
  assign rd_a_bool = st_q.rd_a_bool;
  assign preg_rdata = st_q.preg_rdata;
  assign pc = st_q.pc;
  assign processor_status_word = st_q.psw;
  assign exception_stack_pointer = st_q.esp;
  assign dispatch_table_base = st_q.dtb;
  assign user_mode = st_q.psw[CRF_PSW_U];
  assign illegal_address_trap = st_q.trap;
  assign preg_refused = st_q.refused;

endmodule

// File: tb/crf_sw_model.sv
// Pipeline-side model of software preparing processor register write data
`timescale 1ns/1ps
module crf_sw_model
  import crf_pkg::*;
(
  // Request from the instruction stream
  input wire crf_preg_t preg_sel,
  input wire logic [CRF_DW-1:0] sw_value,
  // Data handed to the register file
  output logic [CRF_DW-1:0] preg_wdata
);
  // Software keeps reserved status bits at zero
  assign preg_wdata = (preg_sel == CRF_PR_STATUS) ? (sw_value & 32'h0000_0EEF) : sw_value;
endmodule

// File: tb/crf_core_regs_props.sv
// Concurrent checks on the register set ports
`timescale 1ns/1ps
module crf_core_regs_props
  import crf_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic core_reset,
  input wire logic pc_load,
  input wire logic [CRF_DW-1:0] pc_value,
  input wire logic stack_op,
  input wire logic [CRF_DW-1:0] rd_a_data,
  input wire logic rd_a_bool,
  input wire logic [CRF_DW-1:0] pc,
  input wire logic [CRF_WW-1:0] processor_status_word,
  input wire logic [CRF_DW-1:0] exception_stack_pointer,
  input wire logic [CRF_DW-1:0] dispatch_table_base,
  input wire logic user_mode,
  input wire logic illegal_address_trap
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  sequence s_lone_trap;
    illegal_address_trap && !stack_op;
  endsequence
  a_pc_even: assert property (pc[0] == 1'b0 && pc[31:24] == 8'h00)
    else $error("pc odd or wider than 24 bits");
  a_pc_load: assert property (pc_load && !core_reset |=> pc == ($past(pc_value) & CRF_PTR_MASK))
    else $error("pc load value wrong");
  a_pc_start: assert property (core_reset |=> pc == CRF_PC_RESET)
    else $error("pc not at start address after core reset");
  a_status_reset: assert property (core_reset |=> processor_status_word[11:0] == 12'h200)
    else $error("status not cleared with E set");
  a_status_zero: assert property (!processor_status_word[4] && !processor_status_word[8])
    else $error("constant status bit set");
  a_stack_forced: assert property ((exception_stack_pointer & ~CRF_PTR_MASK) == 32'h0000_0000)
    else $error("exception stack pointer forced bit set");
  a_base_forced: assert property ((dispatch_table_base & ~CRF_PTR_MASK) == 32'h0000_0000)
    else $error("dispatch base forced bit set");
  a_user_bit: assert property (user_mode == processor_status_word[CRF_PSW_U])
    else $error("user mode differs from status bit");
  a_bool_bit: assert property (rd_a_bool == rd_a_data[0])
    else $error("boolean not lowest bit");
  a_trap_cause: assert property (illegal_address_trap |-> $past(stack_op))
    else $error("trap without stack operation");
  a_trap_once: assert property (s_lone_trap |=> !illegal_address_trap)
    else $error("trap longer than one cycle");
endmodule
bind crf_core_regs crf_core_regs_props i_crf_core_regs_props (.clk_sys, .arst_n, .core_reset,
  .pc_load, .pc_value, .stack_op, .rd_a_data, .rd_a_bool, .pc, .processor_status_word,
  .exception_stack_pointer, .dispatch_table_base, .user_mode, .illegal_address_trap);

// File: tb/test_crf_core_regs.sv
// Self-checking bench for the register set
`timescale 1ns/1ps
module test_crf_core_regs
  import crf_pkg::*;
;
  logic clk_sys = 0, arst_n = 0, core_reset = 0, short_register_select = 1, rd_a_signed = 0;
  logic rd_b_signed = 0, wr_en = 0, pc_load = 0, preg_rd = 0, preg_wr = 0, exc_push = 0;
  logic exc_pop = 0, stack_op = 0, rd_a_bool, user_mode, illegal_address_trap, preg_refused;
  logic [3:0] rd_a_idx = 0, rd_b_idx = 0, wr_idx = 0;
  logic [4:0] exc_bytes = 5'h04;
  crf_size_t rd_a_size = CRF_SZ_BYTE, rd_b_size = CRF_SZ_BYTE, wr_size = CRF_SZ_BYTE;
  crf_preg_t preg_sel = CRF_PR_STATUS;
  logic [31:0] wr_data = 0, pc_value = 32'h0123_4567, sw_value = 0, preg_wdata;
  logic [31:0] rd_a_data, rd_b_data, preg_rdata, pc, exception_stack_pointer, dispatch_table_base;
  logic [15:0] processor_status_word;
  int failures = 0, num_checks = 0;

  crf_sw_model i_crf_sw_model (.preg_sel, .sw_value, .preg_wdata);
  crf_core_regs i_crf_core_regs (.clk_sys, .arst_n, .core_reset, .short_register_select,
    .rd_a_idx, .rd_a_size, .rd_a_signed, .rd_b_idx, .rd_b_size, .rd_b_signed, .wr_en, .wr_idx,
    .wr_size, .wr_data, .pc_load, .pc_value, .preg_rd, .preg_wr, .preg_sel, .preg_wdata,
    .exc_push, .exc_pop, .exc_bytes, .stack_op, .rd_a_data, .rd_b_data, .rd_a_bool, .preg_rdata,
    .pc, .processor_status_word, .exception_stack_pointer, .dispatch_table_base, .user_mode,
    .illegal_address_trap, .preg_refused);

  always #25 clk_sys = ~clk_sys;

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic complete_run;
    if (failures == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic wr(input logic [3:0] i, input crf_size_t s, input logic [31:0] d);
    @(posedge clk_sys);
    wr_en <= 1'b1;
    wr_idx <= i;
    wr_size <= s;
    wr_data <= d;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] i, input crf_size_t s, input logic g, input logic [31:0] e);
    @(posedge clk_sys);
    rd_a_idx <= i;
    rd_b_idx <= i;
    rd_a_size <= s;
    rd_b_size <= s;
    rd_a_signed <= g;
    rd_b_signed <= g;
    @(posedge clk_sys);
    #1;
    chk("rd_a_data", e, rd_a_data);
    chk("rd_b_data", e, rd_b_data);
  endtask

  task automatic preg(input logic w, input crf_preg_t sel, input logic [31:0] v);
    @(posedge clk_sys);
    preg_wr <= w;
    preg_rd <= !w;
    preg_sel <= sel;
    sw_value <= v;
    @(posedge clk_sys);
    preg_wr <= 1'b0;
    preg_rd <= 1'b0;
    #1;
  endtask

  task automatic pls(input int k);
    @(posedge clk_sys);
    case (k)
      0: pc_load <= 1'b1;
      1: core_reset <= 1'b1;
      2: exc_push <= 1'b1;
      3: exc_pop <= 1'b1;
      default: stack_op <= 1'b1;
    endcase
    @(posedge clk_sys);
    {pc_load, core_reset, exc_push, exc_pop, stack_op} <= 5'h00;
    #1;
  endtask

  initial
  begin
    repeat (10) @(posedge clk_sys);
    arst_n <= 1'b1;
    #1;
    chk("pc", 32'h0000_0000, pc);
    chk("status", 32'h0000_0200, {16'h0000, processor_status_word});
    wr(4'h2, CRF_SZ_DWORD, 32'h1234_5678);
    rd(4'h2, CRF_SZ_DWORD, 1'b0, 32'h1234_5678);
    rd(4'h3, CRF_SZ_WORD, 1'b0, 32'h0000_1234);
    wr(4'h2, CRF_SZ_BYTE, 32'h0000_00AB);
    rd(4'h2, CRF_SZ_WORD, 1'b0, 32'h0000_56AB);
    rd(4'h2, CRF_SZ_BYTE, 1'b1, 32'hFFFF_FFAB);
    wr(4'h2, CRF_SZ_WORD, 32'hFFFF_9999);
    rd(4'h3, CRF_SZ_WORD, 1'b0, 32'h0000_1234);
    @(posedge clk_sys);
    short_register_select <= 1'b0;
    wr(4'hC, CRF_SZ_DWORD, 32'hCAFE_BABE);
    rd(4'hC, CRF_SZ_DWORD, 1'b0, 32'hCAFE_BABE);
    rd(4'hD, CRF_SZ_DWORD, 1'b0, 32'h0000_0000);
    @(posedge clk_sys);
    short_register_select <= 1'b1;
    rd(4'hC, CRF_SZ_DWORD, 1'b0, 32'h0000_BABE);
    pls(0);
    chk("pc", 32'h0023_4566, pc);
    preg(1'b1, CRF_PR_STATUS, 32'hFFFF_FFF7);
    chk("status", 32'h0000_0EE7, {16'h0000, processor_status_word});
    pls(1);
    chk("pc", 32'h0000_0000, pc);
    chk("status", 32'h0000_0200, {16'h0000, processor_status_word});
    rd(4'h0, CRF_SZ_DWORD, 1'b0, 32'h0023_4566);
    rd(4'h2, CRF_SZ_WORD, 1'b0, 32'h0000_0EE7);
    preg(1'b1, CRF_PR_EXC_SP, 32'hFFFF_FFFF);
    chk("esp", 32'h00FF_FFFE, exception_stack_pointer);
    preg(1'b1, CRF_PR_DISPATCH, 32'hFFFF_FFFF);
    chk("base", 32'h00FF_FFFE, dispatch_table_base);
    pls(2);
    chk("esp", 32'h00FF_FFFA, exception_stack_pointer);
    pls(3);
    chk("esp", 32'h00FF_FFFE, exception_stack_pointer);
    preg(1'b0, CRF_PR_EXC_SP, 32'h0000_0000);
    chk("preg_rdata", 32'h00FF_FFFE, preg_rdata);
    preg(1'b0, CRF_PR_NONE, 32'h0000_0000);
    chk("preg_rdata", 32'h0000_0000, preg_rdata);
    preg(1'b1, CRF_PR_USER_SP, 32'h0100_0000);
    pls(4);
    chk("trap", 32'h1, {31'h0, illegal_address_trap});
    preg(1'b1, CRF_PR_USER_SP, 32'h00FF_FFFF);
    pls(4);
    chk("trap", 32'h0, {31'h0, illegal_address_trap});
    preg(1'b1, CRF_PR_STATUS, 32'h0000_0008);
    chk("user_mode", 32'h1, {31'h0, user_mode});
    preg(1'b1, CRF_PR_EXC_SP, 32'h0000_0000);
    chk("refused", 32'h1, {31'h0, preg_refused});
    chk("esp", 32'h00FF_FFFE, exception_stack_pointer);
    complete_run();
  end

  initial
  begin
    repeat (2000) @(posedge clk_sys);
    failures++;
    complete_run();
  end
endmodule
